// [rtl/generator_protection_monitor.sv]
// Generator protection monitor: frequency, charger, overcurrent, remote stop and
// operating-conditions faults, configured over an Avalon-MM slave.
// Assumes all measurement and engine inputs come from logic on i_clk.
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`default_nettype none
`include "gpm_cfg.svh"

module generator_protection_monitor #(
  parameter int TICK_CYCLES = `GPM_TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [15:0] i_gen_freq,
  input wire logic [15:0] i_excitation_mv,
  input wire logic [2:0][15:0] i_phase_current,
  input wire logic [2:0] i_phase_valid,
  input wire logic i_current_acquired,
  input wire logic [15:0] i_gen_volt_min,
  input wire logic i_volts_ok,
  input wire logic [2:0] i_engine_state,
  input wire logic i_generator_breaker_closed,
  input wire logic i_regen_active,
  input wire logic i_remote_stop,
  output logic o_underfreq_fault,
  output logic o_overfreq_fault,
  output logic o_charger_failure_fault,
  output logic o_overcurrent_fault,
  output logic o_remote_stop_fault,
  output logic o_operating_conditions_fault,
  output logic [1:0] o_charger_class,
  output logic [1:0] o_overcurrent_class,
  output logic o_open_breaker,
  output logic o_stop_engine_immediate
);

  // ==========================================================================
  // Helper functions
  // ==========================================================================

  // Next value of a persistence timer: cleared when the condition is absent.
  function automatic logic [15:0] persist(input logic [15:0] cnt, input logic cond,
                                          input logic [15:0] dly, input logic tick);
    logic [15:0] r;
    r = cnt;
    if (!cond) begin
      r = 16'h0000;
    end else if (tick && (cnt < dly)) begin
      r = cnt + 16'h0001;
    end
    return r;
  endfunction

  // A persistence timer has expired with its condition still present.
  function automatic logic expired(input logic [15:0] cnt, input logic cond, input logic [15:0] dly);
    return cond && (dly != 16'h0000) && (cnt >= dly);
  endfunction

  // ==========================================================================
  // State and decoded configuration
  // ==========================================================================

  gpm_pkg::state_t st_reg;
  gpm_pkg::state_t st_next;
  gpm_pkg::mode_t mode;
  gpm_pkg::engine_t eng;
  logic traction, async_gen, exc_sense, run_modes, auto_modes, eng_active;
  logic uf_cond, of_cond, chg_cond, oc_cond, opc_cond;
  logic uf_en, of_en, chg_en, oc_en, opc_en, inv_curve, oc_over;
  logic [15:0] imax;
  logic [31:0] thr_base, thr_calc;
  logic [15:0] thr;
  logic [31:0] imax_sq, thr_sq;
  logic [47:0] i2t_limit;
  logic [`GPM_NUM_FLT-1:0] flt_set, flt_clr;
  logic req, hit_cfg, hit_status;
  logic [3:0] idx;

  // Configuration fields and mode grouping.
  assign mode = gpm_pkg::mode_t'(st_reg.cfg[`GPM_IDX_CTRL][`GPM_CTRL_MODE_LSB +: 3]);
  assign eng = gpm_pkg::engine_t'(i_engine_state);
  assign traction = st_reg.cfg[`GPM_IDX_CTRL][`GPM_CTRL_TRACTION];
  assign async_gen = st_reg.cfg[`GPM_IDX_CTRL][`GPM_CTRL_ASYNC];
  assign exc_sense = st_reg.cfg[`GPM_IDX_CTRL][`GPM_CTRL_EXC_SENSE];
  assign run_modes = (mode == gpm_pkg::MODE_HAND) || (mode == gpm_pkg::MODE_AUTO) ||
                     (mode == gpm_pkg::MODE_TEST) || (mode == gpm_pkg::MODE_REMOTE);
  assign auto_modes = (mode == gpm_pkg::MODE_AUTO) || (mode == gpm_pkg::MODE_TEST) ||
                      (mode == gpm_pkg::MODE_REMOTE);
  assign eng_active = (eng == gpm_pkg::ENG_IDLE) || (eng == gpm_pkg::ENG_RUNNING);

  // ==========================================================================
  // Frequency, charger and operating-conditions enables
  // ==========================================================================

  // Under-frequency is held off in hand operation with the breaker open unless unmasked.
  assign uf_en = run_modes && !traction && !async_gen && eng_active && st_reg.ok_seen &&
                 !((mode == gpm_pkg::MODE_HAND) && !i_generator_breaker_closed &&
                   !st_reg.cfg[`GPM_IDX_BRK_MASK][`GPM_BRK_MASK_UF]);
  assign uf_cond = uf_en && (i_gen_freq < st_reg.cfg[`GPM_IDX_UF_THR]);
  assign of_en = run_modes && !traction && !async_gen && eng_active && !i_regen_active;
  assign of_cond = of_en && (i_gen_freq > st_reg.cfg[`GPM_IDX_OF_THR]);
  assign chg_en = run_modes && exc_sense && eng_active;
  assign chg_cond = chg_en && (i_excitation_mv < `GPM_EXC_MIN_MV);
  assign opc_en = auto_modes && !traction && (eng == gpm_pkg::ENG_RUNNING);
  assign opc_cond = opc_en && !st_reg.ok_seen;

  // ==========================================================================
  // Overcurrent threshold and measurement
  // ==========================================================================

  // Largest current over the phases that are available.
  always_comb begin
    imax = 16'h0000;
    for (int p = 0; p < 3; p++) begin
      if (i_phase_valid[p] && (i_phase_current[p] > imax)) begin
        imax = i_phase_current[p];
      end
    end
  end

  // Threshold from percent of rated current, optionally restrained by the lowest voltage.
  always_comb begin
    logic [47:0] prod;
    logic [31:0] vmin_pct, vr_hi, vr_lo;
    prod = 48'(st_reg.cfg[`GPM_IDX_RATED_I]) * 48'(st_reg.cfg[`GPM_IDX_OC_THR]);
    thr_base = 32'(prod / 48'(`GPM_PCT_FULL));
    vmin_pct = 32'(i_gen_volt_min) * `GPM_PCT_FULL;
    vr_hi = 32'(st_reg.cfg[`GPM_IDX_RATED_V]) * `GPM_VR_HIGH_PCT;
    vr_lo = 32'(st_reg.cfg[`GPM_IDX_RATED_V]) * `GPM_VR_LOW_PCT;
    thr_calc = thr_base;
    if (st_reg.cfg[`GPM_IDX_OC_CURVE][0] && (st_reg.cfg[`GPM_IDX_RATED_V] != 16'h0000)) begin
      if (vmin_pct <= vr_lo) begin
        thr_calc = 32'((48'(thr_base) * 48'(`GPM_VR_LOW_PCT)) / 48'(`GPM_PCT_FULL));
      end else if (vmin_pct <= vr_hi) begin
        prod = 48'(thr_base) * 48'(i_gen_volt_min);
        thr_calc = 32'(prod / 48'(st_reg.cfg[`GPM_IDX_RATED_V]));
      end
    end
  end

  // Saturate to the current width and form the I2t quantities.
  assign thr = (thr_calc > 32'h0000_ffff) ? 16'hffff : thr_calc[15:0];
  assign inv_curve = st_reg.cfg[`GPM_IDX_OC_CURVE][1];
  assign oc_en = run_modes && !traction && i_current_acquired && eng_active;
  assign oc_over = imax > thr;
  assign oc_cond = oc_en && oc_over && !inv_curve;
  assign imax_sq = 32'(imax) * 32'(imax);
  assign thr_sq = 32'(thr) * 32'(thr);
  assign i2t_limit = 48'(thr_sq) * 48'(st_reg.cfg[`GPM_IDX_OC_DLY]);

  // ==========================================================================
  // Register bus decode
  // ==========================================================================

  assign req = i_avs_read || i_avs_write;
  assign idx = i_avs_address[5:2];
  assign hit_cfg = (i_avs_address[7:6] == 2'h0) && (i_avs_address[1:0] == 2'h0) &&
                   (idx != `GPM_IDX_STATUS);
  assign hit_status = (i_avs_address[7:6] == 2'h0) && (i_avs_address[1:0] == 2'h0) &&
                      (idx == `GPM_IDX_STATUS);
  // One wait cycle on every access, then the answer at the next edge.
  assign o_avs_waitrequest = req && !st_reg.ack;

  // Write-one-to-clear mask for the fault bits.
  assign flt_clr = (i_avs_write && st_reg.ack && hit_status && i_avs_byteenable[0]) ?
                   i_avs_writedata[`GPM_NUM_FLT-1:0] : '0;

  // ==========================================================================
  // Next state
  // ==========================================================================

  // All sequential behaviour; a new fault event wins over a clear in the same cycle.
  always_comb begin
    st_next = st_reg;
    // Millisecond time base.
    st_next.tick = 1'b0;
    if (st_reg.tick_cnt >= 24'(TICK_CYCLES - 1)) begin
      st_next.tick_cnt = 24'h000000;
      st_next.tick = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 24'h000001;
    end
    // Acceptable-measurement latch, rearmed on every start.
    if ((eng == gpm_pkg::ENG_STOPPED) || (eng == gpm_pkg::ENG_STARTING)) begin
      st_next.ok_seen = 1'b0;
    end else if (i_volts_ok) begin
      st_next.ok_seen = 1'b1;
    end
    // Persistence timers.
    st_next.tmr[0] = persist(st_reg.tmr[0], uf_cond, st_reg.cfg[`GPM_IDX_UF_DLY], st_reg.tick);
    st_next.tmr[1] = persist(st_reg.tmr[1], of_cond, st_reg.cfg[`GPM_IDX_OF_DLY], st_reg.tick);
    st_next.tmr[2] = persist(st_reg.tmr[2], chg_cond, st_reg.cfg[`GPM_IDX_CHG_DLY], st_reg.tick);
    st_next.tmr[3] = persist(st_reg.tmr[3], oc_cond, st_reg.cfg[`GPM_IDX_OC_DLY], st_reg.tick);
    st_next.tmr[4] = persist(st_reg.tmr[4], opc_cond, st_reg.cfg[`GPM_IDX_OPC_DLY], st_reg.tick);
    // Thermal integral: only samples above threshold add, each by its I2t weight.
    if (!oc_en || !inv_curve) begin
      st_next.acc = 48'h0;
    end else if (st_reg.tick && oc_over && (st_reg.acc < i2t_limit)) begin
      st_next.acc = st_reg.acc + 48'(imax_sq - thr_sq);
    end
    // Fault events.
    flt_set = '0;
    flt_set[`GPM_FLT_UF] = expired(st_reg.tmr[0], uf_cond, st_reg.cfg[`GPM_IDX_UF_DLY]);
    flt_set[`GPM_FLT_OF] = expired(st_reg.tmr[1], of_cond, st_reg.cfg[`GPM_IDX_OF_DLY]);
    flt_set[`GPM_FLT_CHG] = expired(st_reg.tmr[2], chg_cond, st_reg.cfg[`GPM_IDX_CHG_DLY]);
    flt_set[`GPM_FLT_OC] = expired(st_reg.tmr[3], oc_cond, st_reg.cfg[`GPM_IDX_OC_DLY]) ||
                           (oc_en && inv_curve && (st_reg.cfg[`GPM_IDX_OC_DLY] != 16'h0000) &&
                            (st_reg.acc >= i2t_limit) && (st_reg.acc != 48'h0));
    flt_set[`GPM_FLT_RSTOP] = auto_modes && i_remote_stop;
    flt_set[`GPM_FLT_OPC] = expired(st_reg.tmr[4], opc_cond, st_reg.cfg[`GPM_IDX_OPC_DLY]);
    st_next.fault = (st_reg.fault & ~flt_clr) | flt_set;
    // Bus slave: capture read data while waiting, apply writes on the answering edge.
    st_next.ack = req && !st_reg.ack;
    if (req && !st_reg.ack) begin
      st_next.rdata = 32'h0000_0000;
      if (hit_cfg) begin
        st_next.rdata = {16'h0000, st_reg.cfg[idx]};
      end else if (hit_status) begin
        st_next.rdata = 32'(st_reg.fault);
      end
    end
    if (i_avs_write && st_reg.ack && hit_cfg) begin
      if (i_avs_byteenable[0]) begin
        st_next.cfg[idx][7:0] = i_avs_writedata[7:0];
      end
      if (i_avs_byteenable[1]) begin
        st_next.cfg[idx][15:8] = i_avs_writedata[15:8];
      end
    end
    if (i_srst) begin
      st_next = '0;
      for (int r = 0; r < `GPM_NUM_CFG; r++) begin
        st_next.cfg[r] = `GPM_CFG_RESET;
      end
    end
  end

  // State register.
  always_ff @(posedge i_clk) begin
    st_reg <= st_next;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================

  // Fault levels and their actions come straight from the state register.
  assign o_avs_readdata = st_reg.rdata;
  assign o_underfreq_fault = st_reg.fault[`GPM_FLT_UF];
  assign o_overfreq_fault = st_reg.fault[`GPM_FLT_OF];
  assign o_charger_failure_fault = st_reg.fault[`GPM_FLT_CHG];
  assign o_overcurrent_fault = st_reg.fault[`GPM_FLT_OC];
  assign o_remote_stop_fault = st_reg.fault[`GPM_FLT_RSTOP];
  assign o_operating_conditions_fault = st_reg.fault[`GPM_FLT_OPC];
  assign o_charger_class = st_reg.cfg[`GPM_IDX_CHG_ACT][1:0];
  assign o_overcurrent_class = st_reg.cfg[`GPM_IDX_OC_ACT][1:0];
  assign o_open_breaker = st_reg.fault[`GPM_FLT_RSTOP];
  assign o_stop_engine_immediate = st_reg.fault[`GPM_FLT_RSTOP];

  // ==========================================================================
  // Assertions
  // ==========================================================================

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence bus_wait_s;
    req && o_avs_waitrequest;
  endsequence

  sequence bus_done_s;
    !o_avs_waitrequest ##1 !st_reg.ack;
  endsequence

  bus_answer_a: assert property (bus_wait_s |=> bus_done_s) else $error("bus answer late");
  uf_zero_dly_a: assert property (
    $rose(o_underfreq_fault) |-> $past(st_reg.cfg[`GPM_IDX_UF_DLY]) != 16'h0000)
    else $error("under-frequency with zero delay");
  uf_start_a: assert property (
    $rose(o_underfreq_fault) |-> $past(st_reg.ok_seen) && $past(eng_active))
    else $error("under-frequency while suppressed");
  uf_hand_a: assert property (
    $rose(o_underfreq_fault) && $past(mode == gpm_pkg::MODE_HAND) |->
    $past(i_generator_breaker_closed || st_reg.cfg[`GPM_IDX_BRK_MASK][`GPM_BRK_MASK_UF]))
    else $error("under-frequency in hand with breaker open");
  of_regen_a: assert property (
    $rose(o_overfreq_fault) |-> !$past(i_regen_active))
    else $error("over-frequency during regeneration");
  chg_input_a: assert property (
    $rose(o_charger_failure_fault) |-> $past(exc_sense))
    else $error("charger fault without sense input");
  oc_acquire_a: assert property (
    $rose(o_overcurrent_fault) |-> $past(i_current_acquired) && !$past(traction))
    else $error("overcurrent while suppressed");
  i2t_below_a: assert property (
    oc_en && inv_curve && !oc_over |=> st_reg.acc <= $past(st_reg.acc))
    else $error("integral grows below threshold");
  rstop_raise_a: assert property (
    i_remote_stop && auto_modes ##1 !flt_clr[`GPM_FLT_RSTOP] |-> o_remote_stop_fault)
    else $error("remote stop not raised");
  rstop_act_a: assert property (
    o_remote_stop_fault |-> o_open_breaker && o_stop_engine_immediate)
    else $error("remote stop actions missing");
  tmr_restart_a: assert property (
    !uf_cond |=> st_reg.tmr[0] == 16'h0000)
    else $error("persistence timer kept");

  // Trip paths: an expired timer or a full integral must raise the fault one clock later.
  sequence uf_expired_s;
    uf_cond && (st_reg.cfg[`GPM_IDX_UF_DLY] != 16'h0000) && (st_reg.tmr[0] >= st_reg.cfg[`GPM_IDX_UF_DLY]);
  endsequence
  sequence i2t_full_s;
    oc_en && inv_curve && (st_reg.cfg[`GPM_IDX_OC_DLY] != 16'h0000) && (st_reg.acc >= i2t_limit) &&
    (st_reg.acc != 48'h0);
  endsequence

  uf_trip_a: assert property (
    uf_expired_s |=> o_underfreq_fault)
    else $error("under-frequency timer expired without fault");
  uf_sticky_a: assert property (
    o_underfreq_fault && !flt_clr[`GPM_FLT_UF] |=> o_underfreq_fault)
    else $error("under-frequency fault lost");
  of_zero_dly_a: assert property (
    $rose(o_overfreq_fault) |-> $past(st_reg.cfg[`GPM_IDX_OF_DLY]) != 16'h0000)
    else $error("over-frequency with zero delay");
  of_run_a: assert property (
    $rose(o_overfreq_fault) |-> $past(run_modes && eng_active && !traction && !async_gen))
    else $error("over-frequency while suppressed");
  chg_zero_dly_a: assert property (
    $rose(o_charger_failure_fault) |-> $past(st_reg.cfg[`GPM_IDX_CHG_DLY]) != 16'h0000)
    else $error("charger fault with zero delay");
  oc_curve0_a: assert property (
    $rose(o_overcurrent_fault) && !$past(inv_curve) |-> $past(oc_over))
    else $error("immediate overcurrent without overload");
  thr_restrain_a: assert property (
    thr_calc <= thr_base)
    else $error("restrained threshold above configured threshold");
  i2t_clear_a: assert property (
    !oc_en || !inv_curve |=> st_reg.acc == 48'h0)
    else $error("integral kept while not in use");
  i2t_trip_a: assert property (
    i2t_full_s |=> o_overcurrent_fault)
    else $error("full integral without overcurrent fault");
  oc_mode_a: assert property (
    $rose(o_overcurrent_fault) |-> $past(run_modes && eng_active))
    else $error("overcurrent outside its modes");
  rstop_mode_a: assert property (
    $rose(o_remote_stop_fault) |-> $past(auto_modes))
    else $error("remote stop fault outside automatic modes");
  opc_cond_a: assert property (
    $rose(o_operating_conditions_fault) |->
    $past((eng == gpm_pkg::ENG_RUNNING) && auto_modes && !st_reg.ok_seen))
    else $error("operating-conditions fault while suppressed");

endmodule

`default_nettype wire

// [rtl/gpm_cfg.svh]
// Register indices, field positions, reset values and timing constants of the
// generator protection monitor. Byte address of a register is its index times four.
`ifndef GPM_CFG_SVH
`define GPM_CFG_SVH

// Clock and protection time base.
`define GPM_CLK_NS 50
`define GPM_TICK_NS 1000000
`define GPM_TICK_CYCLES (`GPM_TICK_NS / `GPM_CLK_NS)

// Register indices (word addresses).
`define GPM_IDX_CTRL 4'h0
`define GPM_IDX_BRK_MASK 4'h1
`define GPM_IDX_UF_THR 4'h2
`define GPM_IDX_UF_DLY 4'h3
`define GPM_IDX_OF_THR 4'h4
`define GPM_IDX_OF_DLY 4'h5
`define GPM_IDX_CHG_DLY 4'h6
`define GPM_IDX_CHG_ACT 4'h7
`define GPM_IDX_OC_CURVE 4'h8
`define GPM_IDX_OC_THR 4'h9
`define GPM_IDX_OC_DLY 4'ha
`define GPM_IDX_OC_ACT 4'hb
`define GPM_IDX_OPC_DLY 4'hc
`define GPM_IDX_RATED_I 4'hd
`define GPM_IDX_RATED_V 4'he
`define GPM_IDX_STATUS 4'hf
`define GPM_NUM_CFG 15

// Control and breaker mask register fields.
`define GPM_CTRL_MODE_LSB 0
`define GPM_CTRL_TRACTION 4
`define GPM_CTRL_ASYNC 5
`define GPM_CTRL_EXC_SENSE 6
`define GPM_BRK_MASK_UF 2

// Status register fault bits.
`define GPM_FLT_UF 0
`define GPM_FLT_OF 1
`define GPM_FLT_CHG 2
`define GPM_FLT_OC 3
`define GPM_FLT_RSTOP 4
`define GPM_FLT_OPC 5
`define GPM_NUM_FLT 6

// Reset value of every configuration register: all protections disabled.
`define GPM_CFG_RESET 16'h0000

// Excitation sense limit in millivolts, and voltage-restraint breakpoints in percent.
`define GPM_EXC_MIN_MV 16'h1770
`define GPM_VR_HIGH_PCT 32'h0000_0050
`define GPM_VR_LOW_PCT 32'h0000_0014
`define GPM_PCT_FULL 32'h0000_0064

`endif

// [rtl/gpm_pkg.sv]
// Types shared by the generator protection monitor.
// Assumes gpm_cfg.svh is compiled alongside.
`default_nettype none
`include "gpm_cfg.svh"

package gpm_pkg;

  // Operating mode of the controller.
  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    MODE_HAND = 3'h1,
    MODE_AUTO = 3'h3,
    MODE_TEST = 3'h2,
    MODE_REMOTE = 3'h6
  } mode_t;

  // Engine sequencing state, Gray coded along the start-run-stop path.
  typedef enum logic [2:0] {
    ENG_STOPPED = 3'h0,
    ENG_STARTING = 3'h1,
    ENG_IDLE = 3'h3,
    ENG_RUNNING = 3'h2,
    ENG_STOPPING = 3'h6
  } engine_t;

  // Fault class carried with configurable faults.
  typedef enum logic [1:0] {
    CLS_WARNING = 2'h0,
    CLS_DEACTIVATION = 2'h1,
    CLS_UNLOAD = 2'h2,
    CLS_ALARM = 2'h3
  } fault_class_t;

  // Whole state of the monitor.
  typedef struct packed {
    logic [`GPM_NUM_CFG-1:0][15:0] cfg;
    logic [`GPM_NUM_FLT-1:0] fault;
    logic [4:0][15:0] tmr;
    logic [47:0] acc;
    logic [23:0] tick_cnt;
    logic tick;
    logic ok_seen;
    logic ack;
    logic [31:0] rdata;
  } state_t;

endpackage

`default_nettype wire

// [verif/generator_protection_monitor_tb.sv]
// Self-checking bench of the generator protection monitor.
// Assumes the design and the source model compile first; tick shortened to 10 clocks.
`default_nettype none
module generator_protection_monitor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0, i_srst = 1'b1, rd = 1'b0, wr = 1'b0, start = 1'b0, cmd_v = 1'b0;
  logic [7:0] addr = 8'h00, code = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic waitreq, regen = 1'b0, vok = 1'b0, acq = 1'b0, brk = 1'b0, rstop;
  logic [15:0] freq = 16'h0050, exc = 16'h2000, vmin = 16'h0064;
  logic [2:0][15:0] cur = '0;
  logic [2:0] pvalid = 3'h7, eng;
  logic [5:0] flt;
  logic [1:0] chg_cls, oc_cls;
  logic open_brk, stop_imm;
  int miscompares = 0, total_checks = 0;
  gpm_source_model model (.i_clk(i_clk), .i_srst(i_srst), .i_start(start), .i_cmd_valid(cmd_v),
    .i_cmd_code(code), .o_engine_state(eng), .o_remote_stop(rstop));
  generator_protection_monitor #(.TICK_CYCLES(10)) dut (.i_clk(i_clk), .i_srst(i_srst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_gen_freq(freq), .i_excitation_mv(exc),
    .i_phase_current(cur), .i_phase_valid(pvalid), .i_current_acquired(acq), .i_gen_volt_min(vmin),
    .i_volts_ok(vok), .i_engine_state(eng), .i_generator_breaker_closed(brk), .i_regen_active(regen),
    .i_remote_stop(rstop), .o_underfreq_fault(flt[0]), .o_overfreq_fault(flt[1]),
    .o_charger_failure_fault(flt[2]), .o_overcurrent_fault(flt[3]), .o_remote_stop_fault(flt[4]),
    .o_operating_conditions_fault(flt[5]), .o_charger_class(chg_cls), .o_overcurrent_class(oc_cls),
    .o_open_breaker(open_brk), .o_stop_engine_immediate(stop_imm));
  // ============================================================
  // Clock and shared tasks.
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One Avalon access; the request stands until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) chk(32'h1, 32'h0);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // ============================================================
  // Scenarios.
  task automatic t_regs();
    bus(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 8'h08, 32'hffff_0064);
    bus(1'b0, 8'h08, 32'h0);
    chk(q, 32'h0000_0064);
    bus(1'b0, 8'h41, 32'h0);
    chk(q, 32'h0);
  endtask
  task automatic t_freq();
    bus(1'b1, 8'h00, 32'h3);
    bus(1'b1, 8'h30, 32'h2);
    start <= 1'b1;
    bus(1'b1, 8'h0c, 32'h2);
    bus(1'b1, 8'h10, 32'h0040);
    bus(1'b1, 8'h14, 32'h2);
    regen <= 1'b1;
    wait_cyc(40);
    chk(flt[1:0], 2'b00);
    chk(flt[5], 1'b1);
    vok <= 1'b1;
    wait_cyc(6);
    chk(flt[0], 1'b0);
    wait_cyc(34);
    chk(flt[1:0], 2'b01);
    chk(flt[1], 1'b0);
    regen <= 1'b0;
    freq <= 16'h0070;
    wait_cyc(40);
    chk(flt[1], 1'b1);
  endtask
  task automatic t_chg_oc();
    bus(1'b1, 8'h00, 32'h43);
    bus(1'b1, 8'h1c, 32'h3);
    exc <= 16'h176f;
    bus(1'b1, 8'h18, 32'h2);
    bus(1'b1, 8'h34, 32'h0064);
    bus(1'b1, 8'h24, 32'h0064);
    bus(1'b1, 8'h2c, 32'h2);
    bus(1'b1, 8'h28, 32'h2);
    cur[1] <= 16'h0096;
    wait_cyc(40);
    chk(flt[3], 1'b0);
    acq <= 1'b1;
    wait_cyc(40);
    chk({flt[3:2], chg_cls, oc_cls}, 6'b11_11_10);
  endtask
  // Inverse, voltage-restrained and combined curves on phase 2, threshold 100.
  task automatic t_oc_curves();
    cur[1] <= 16'h0064;
    bus(1'b1, 8'h20, 32'h2);
    bus(1'b1, 8'h3c, 32'h8);
    wait_cyc(40);
    chk(flt[3], 1'b0);
    cur[1] <= 16'h0096;
    wait_cyc(10);
    cur[1] <= 16'h0064;
    wait_cyc(20);
    chk(flt[3], 1'b0);
    cur[1] <= 16'h0096;
    wait_cyc(10);
    cur[1] <= 16'h0064;
    wait_cyc(3);
    chk(flt[3], 1'b1);
    bus(1'b1, 8'h20, 32'h1);
    cur[1] <= 16'h003c;
    bus(1'b1, 8'h38, 32'h64);
    bus(1'b1, 8'h3c, 32'h8);
    wait_cyc(40);
    chk(flt[3], 1'b0);
    vmin <= 16'h0032;
    wait_cyc(40);
    chk(flt[3], 1'b1);
    cur[1] <= 16'h0019;
    bus(1'b1, 8'h3c, 32'h8);
    wait_cyc(40);
    chk(flt[3], 1'b0);
    vmin <= 16'h000a;
    wait_cyc(40);
    chk(flt[3], 1'b1);
    bus(1'b1, 8'h20, 32'h3);
    bus(1'b1, 8'h3c, 32'h8);
    wait_cyc(60);
    chk(flt[3], 1'b1);
  endtask
  task automatic t_rstop();
    logic [7:0] codes [2] = '{8'h15, 8'h16};
    logic [2:0] exp;
    for (int i = 0; i < 2; i++) begin
      @(posedge i_clk);
      cmd_v <= 1'b1;
      code <= codes[i];
      @(posedge i_clk);
      cmd_v <= 1'b0;
      wait_cyc(3);
      exp = {3{i == 1}};
      chk({flt[4], open_brk, stop_imm}, exp);
    end
    bus(1'b1, 8'h3c, 32'h10);
    wait_cyc(2);
    chk(flt[4], 1'b0);
    bus(1'b1, 8'h00, 32'h1);
    cmd_v <= 1'b1;
    @(posedge i_clk);
    cmd_v <= 1'b0;
    wait_cyc(3);
    chk(flt[4], 1'b0);
    freq <= 16'h0050;
    bus(1'b1, 8'h3c, 32'h1);
    wait_cyc(40);
    chk(flt[0], 1'b0);
    bus(1'b1, 8'h04, 32'h4);
    wait_cyc(40);
    chk(flt[0], 1'b1);
  endtask
  // ============================================================
  // Verdict and run control.
  task automatic final_report();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    wait_cyc(6);
    i_srst <= 1'b0;
    t_regs();
    t_freq();
    t_chg_oc();
    t_oc_curves();
    t_rstop();
    final_report();
  end
  initial begin
    wait_cyc(3000);
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire

// [verif/gpm_source_model.sv]
// Partner model: command decoder of the comm ports and engine sequencer.
// Assumes the bench drives its requests by non-blocking assignment on i_clk.
`default_nettype none
module gpm_source_model (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_start,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_code,
  output logic [2:0] o_engine_state,
  output logic o_remote_stop
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] step_reg;
  // ============================================================
  // Stop pulse only for the manual stop code; engine walks to running.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      step_reg <= 4'h0;
      o_remote_stop <= 1'b0;
      o_engine_state <= gpm_pkg::ENG_STOPPED;
    end else begin
      o_remote_stop <= i_cmd_valid && (i_cmd_code == 8'h16);
      if ((i_start && step_reg == 4'h0) || (step_reg != 4'h0 && step_reg != 4'hf)) begin
        step_reg <= step_reg + 4'h1;
      end
      o_engine_state <= (step_reg == 4'h0) ? gpm_pkg::ENG_STOPPED : (step_reg < 4'h4) ? gpm_pkg::ENG_STARTING :
                        (step_reg < 4'h8) ? gpm_pkg::ENG_IDLE : gpm_pkg::ENG_RUNNING;
    end
  end
endmodule
`default_nettype wire
